// [sim/tcm_assertions.sv]
/* tcm_assertions: bus and channel checks on the ports of tcm_top.
   assumes i_hready is the slave's own o_hreadyout. */
`timescale 1ns/100ps
module tcm_assertions (
   input wire logic i_clk,
   input wire logic i_nrst,
   input wire logic i_hsel,
   input wire logic [31:0] i_haddr,
   input wire logic [1:0] i_htrans,
   input wire logic i_hwrite,
   input wire logic [2:0] i_hsize,
   input wire logic [31:0] i_hwdata,
   input wire logic i_hready,
   input wire logic [31:0] o_hrdata,
   input wire logic o_hreadyout,
   input wire logic o_hresp,
   input wire logic i_timer_input_one,
   input wire logic i_internal_trigger_source,
   input wire logic o_ch1_reference_output,
   input wire logic o_ch1_capture_input,
   input wire logic o_ch2_capture_input
);
   import tcm_pkg::*;
   // ----------------------------------------
   // shadow of the mode word
   // ----------------------------------------
   default clocking cb @(posedge i_clk);
   endclocking
   default disable iff (!i_nrst);
   logic taken, wr_mode_r;
   logic [15:0] mode_r;
   assign taken = i_hsel && i_hready && i_htrans[1] && i_hsize == TCM_HSIZE_WORD;
   // only direction bits are trusted: locked mode bits may be dropped by the design
   always_ff @(posedge i_clk or negedge i_nrst) begin
      if (!i_nrst) begin
         wr_mode_r <= 1'b0;
         mode_r <= 16'h0000;
      end else if (i_hready) begin
         wr_mode_r <= taken && i_hwrite && i_haddr == TCM_ADDR_MODE;
         if (wr_mode_r) mode_r <= i_hwdata[15:0];
      end
   end
   // ----------------------------------------
   // properties
   // ----------------------------------------
   AST_HRESP_OKAY: assert property (o_hresp == 1'b0)
      else $error("error response seen");
   AST_READ_WAIT: assert property (taken && !i_hwrite |=> !o_hreadyout ##1 o_hreadyout)
      else $error("read wait state wrong");
   AST_WRITE_NOWAIT: assert property (taken && i_hwrite |=> o_hreadyout)
      else $error("write stalled");
   AST_RDATA_HOLD: assert property (o_hreadyout && $past(o_hreadyout) |-> $stable(o_hrdata))
      else $error("read data moved outside a read");
   AST_UPPER_ZERO: assert property (o_hrdata[31:16] == 16'h0000)
      else $error("upper read bits not zero");
   AST_OUT_NO_CAP: assert property ((mode_r[1:0] == 2'b00)[*3] |-> !o_ch1_capture_input)
      else $error("capture active on output channel");
   AST_IN_REF_LOW: assert property ((mode_r[1:0] != 2'b00)[*3] |-> !o_ch1_reference_output)
      else $error("reference active on input channel");
   AST_CH1_ONE: assert property ((mode_r[1:0] == 2'b01 && $stable(i_timer_input_one))[*5]
      |-> o_ch1_capture_input == i_timer_input_one) else $error("ch1 input one wrong");
   AST_CH2_ONE: assert property ((mode_r[9:8] == 2'b10 && $stable(i_timer_input_one))[*5]
      |-> o_ch2_capture_input == i_timer_input_one) else $error("ch2 input one wrong");
   AST_CH2_TRG: assert property ((mode_r[9:8] == 2'b11 && $stable(i_internal_trigger_source))[*5]
      |-> o_ch2_capture_input == i_internal_trigger_source) else $error("ch2 trigger wrong");
   COV_READ: cover property (taken && !i_hwrite);
   COV_CH1_IN: cover property (mode_r[1:0] == 2'b01 && o_ch1_capture_input);
   COV_CH2_TRG: cover property (mode_r[9:8] == 2'b11 && o_ch2_capture_input);
endmodule : tcm_assertions

bind tcm_top tcm_assertions tcm_assertions_i (.*);

// [sim/tcm_top_test.sv]
/* tcm_top_test: self-checking bench for tcm_top.
   assumes one bus master and hready looped back from hreadyout. */
`timescale 1ns/100ps
module tcm_top_test;
   import tcm_pkg::*;
   // ----------------------------------------
   // signals and rows
   // ----------------------------------------
   typedef struct {logic ch; logic [7:0] mb; logic [15:0] cnt; logic etr; logic ref_v;} tcm_row_s;
   logic i_clk, i_nrst, i_hsel, i_hwrite, i_hready, o_hreadyout, o_hresp;
   logic [31:0] i_haddr, i_hwdata, o_hrdata, rd;
   logic [1:0] i_htrans;
   logic [2:0] i_hsize;
   logic [15:0] i_counter_value;
   logic i_update_event, i_trigger_event, i_filtered_external_trigger;
   logic i_timer_input_one, i_timer_input_two, i_internal_trigger_source;
   logic o_ch1_reference_output, o_ch2_reference_output;
   logic o_ch1_capture_input, o_ch2_capture_input;
   int error_cnt, num_checks, cyc;
   tcm_row_s rows[11] = '{'{1'h0, 8'h40, 16'h0005, 1'h0, 1'h0}, '{1'h0, 8'h10, 16'h000a, 1'h0, 1'h1},
      '{1'h0, 8'h00, 16'h0003, 1'h0, 1'h1}, '{1'h1, 8'h50, 16'h0003, 1'h0, 1'h1},
      '{1'h1, 8'h20, 16'h000a, 1'h0, 1'h0}, '{1'h1, 8'h60, 16'h0005, 1'h0, 1'h1},
      '{1'h1, 8'h60, 16'h000a, 1'h0, 1'h0}, '{1'h0, 8'h70, 16'h000b, 1'h0, 1'h1},
      '{1'h0, 8'h70, 16'h000a, 1'h0, 1'h0}, '{1'h0, 8'hd0, 16'h0003, 1'h1, 1'h0},
      '{1'h1, 8'h50, 16'h0003, 1'h1, 1'h1}};
   // the slave is alone on the bus, so its readiness is the bus's
   assign i_hready = o_hreadyout;
   tcm_top tcm_top_i (.*);
   // ----------------------------------------
   // tasks
   // ----------------------------------------
   task automatic check(input logic [31:0] seen, input logic [31:0] exp);
      num_checks++;
      if (seen !== exp) begin
         error_cnt++;
         $display("unexpected at %0t: got %h, want %h", $time, seen, exp);
      end
   endtask : check
   task automatic bus(input logic wr, input logic [31:0] a, input logic [31:0] d);
      @(posedge i_clk);
      i_hsel <= 1'b1;
      i_haddr <= a;
      i_hwrite <= wr;
      i_htrans <= 2'h2;
      do @(posedge i_clk); while (!o_hreadyout);
      i_htrans <= 2'h0;
      i_hwdata <= d;
      do @(posedge i_clk); while (!o_hreadyout);
      rd = o_hrdata;
   endtask : bus
   task automatic rchk(input logic [31:0] a, input logic [31:0] exp);
      bus(1'b0, a, 32'h0);
      check(rd, exp);
   endtask : rchk
   task automatic print_verdict();
      $display("checks %0d, errors %0d", num_checks, error_cnt);
      if (error_cnt == 0 && num_checks > 0) begin
         $display("bench passed");
      end else begin
         $display("bench failed");
      end
      $finish;
   endtask : print_verdict
   // ----------------------------------------
   // clock, timeout and sequence
   // ----------------------------------------
   initial begin
      i_clk = 1'b0;
      forever #5 i_clk = ~i_clk;
   end
   always @(posedge i_clk) begin
      cyc++;
      if (cyc == 20000) begin
         error_cnt++;
         print_verdict();
      end
   end
   initial begin
      {i_nrst, i_hsel, i_hwrite, i_update_event, i_trigger_event, i_htrans} = 7'h00;
      {i_filtered_external_trigger, i_timer_input_one, i_timer_input_two} = 3'h0;
      {i_internal_trigger_source, i_counter_value, i_haddr, i_hwdata} = 81'h0;
      i_hsize = TCM_HSIZE_WORD;
      repeat (5) @(posedge i_clk);
      i_nrst <= 1'b1;
      bus(1'b1, TCM_ADDR_CH1_CC, 32'h000a);
      bus(1'b1, TCM_ADDR_CH2_CC, 32'h000a);
      bus(1'b1, TCM_ADDR_CTRL, 32'h0010);
      foreach (rows[i]) begin
         i_counter_value <= rows[i].cnt;
         i_filtered_external_trigger <= rows[i].etr;
         bus(1'b1, TCM_ADDR_MODE, {16'h0, rows[i].ch ? {rows[i].mb, 8'h00} : {8'h00, rows[i].mb}});
         repeat (3) @(posedge i_clk);
         check(rows[i].ch ? o_ch2_reference_output : o_ch1_reference_output, rows[i].ref_v);
      end
      i_filtered_external_trigger <= 1'b0;
      bus(1'b1, TCM_ADDR_MODE, 32'h0018);
      bus(1'b1, TCM_ADDR_CH1_CC, 32'h0064);
      rchk(TCM_ADDR_CH1_ACT, 32'h000a);
      i_update_event <= 1'b1;
      @(posedge i_clk);
      i_update_event <= 1'b0;
      rchk(TCM_ADDR_CH1_ACT, 32'h0064);
      bus(1'b1, TCM_ADDR_MODE, 32'h0010);
      bus(1'b1, TCM_ADDR_CH1_CC, 32'h0020);
      rchk(TCM_ADDR_CH1_ACT, 32'h0020);
      bus(1'b1, TCM_ADDR_CTRL, 32'h0300);
      bus(1'b1, TCM_ADDR_MODE, 32'h0050);
      rchk(TCM_ADDR_MODE, 32'h0010);
      bus(1'b1, TCM_ADDR_CTRL, 32'h0000);
      bus(1'b1, TCM_ADDR_MODE, 32'h0040);
      bus(1'b1, TCM_ADDR_MODE, 32'h0014);
      i_trigger_event <= 1'b1;
      @(posedge i_clk);
      i_trigger_event <= 1'b0;
      repeat (3) @(posedge i_clk);
      check(o_ch1_reference_output, 1'b1);
      bus(1'b1, TCM_ADDR_MODE, 32'h0030);
      i_counter_value <= 16'h0020;
      @(posedge i_clk);
      i_counter_value <= 16'h0003;
      repeat (3) @(posedge i_clk);
      check(o_ch1_reference_output, 1'b0);
      i_timer_input_one <= 1'b1;
      bus(1'b1, TCM_ADDR_MODE, 32'h0201);
      repeat (6) @(posedge i_clk);
      check({o_ch1_capture_input, o_ch2_capture_input, o_ch1_reference_output}, 3'h6);
      {i_timer_input_one, i_timer_input_two, i_internal_trigger_source} <= 3'h1;
      bus(1'b1, TCM_ADDR_MODE, 32'h0302);
      repeat (6) @(posedge i_clk);
      check({o_ch1_capture_input, o_ch2_capture_input}, 2'h1);
      rchk(32'h0000_0020, 32'h0);
      i_nrst <= 1'b0;
      repeat (2) @(posedge i_clk);
      i_nrst <= 1'b1;
      rchk(TCM_ADDR_MODE, 32'h0);
      rchk(TCM_ADDR_CH1_ACT, 32'h0);
      print_verdict();
   end
endmodule : tcm_top_test

// [verilog/tcm_ahb_slave.sv]
/*
 * tcm_ahb_slave: AHB-Lite slave turning single word transfers into register
 * writes and reads. Assumes it is the only slave, so hready is its own
 * hreadyout. Writes take no wait state, reads take one.
 */
`timescale 1ns/100ps
module tcm_ahb_slave (
   input wire logic i_clk,
   input wire logic i_nrst,
   input wire logic i_hsel,
   input wire logic [31:0] i_haddr,
   input wire logic [1:0] i_htrans,
   input wire logic i_hwrite,
   input wire logic [2:0] i_hsize,
   input wire logic [31:0] i_hwdata,
   input wire logic i_hready,
   output logic [31:0] o_hrdata,
   output logic o_hreadyout,
   output logic o_hresp,
   tcm_regbus_if.bus rb
);
   import tcm_pkg::*;

   logic phase_r;
   logic write_r;
   logic mapped_r;
   logic [TCM_IDX_W-1:0] idx_r;
   logic accept;

   assign accept = i_hsel && i_htrans[TCM_HTRANS_ACT_BIT] && (i_hsize == TCM_HSIZE_WORD);

   // ----------------------------------------------------------------
   // address phase capture
   // ----------------------------------------------------------------
   always_ff @(posedge i_clk or negedge i_nrst) begin
      if (!i_nrst) begin
         phase_r <= 1'b0;
         write_r <= 1'b0;
         mapped_r <= 1'b0;
         idx_r <= '0;
      end else if (i_hready) begin
         phase_r <= accept;
         write_r <= i_hwrite;
         mapped_r <= (i_haddr <= TCM_ADDR_SPAN);
         idx_r <= i_haddr[TCM_IDX_W+1:2];
      end
   end

   // a read waits one cycle so hrdata leaves a flip-flop and sees a
   // write made in the transfer just before
   always_ff @(posedge i_clk or negedge i_nrst) begin
      if (!i_nrst) begin
         o_hreadyout <= 1'b1;
      end else begin
         o_hreadyout <= !(i_hready && accept && !i_hwrite);
      end
   end

   always_ff @(posedge i_clk or negedge i_nrst) begin
      if (!i_nrst) begin
         o_hrdata <= '0;
      end else if (phase_r && !write_r && !o_hreadyout) begin
         o_hrdata <= rb.rdata;
      end
   end

   always_ff @(posedge i_clk or negedge i_nrst) begin
      if (!i_nrst) begin
         o_hresp <= 1'b0;
      end else begin
         o_hresp <= 1'b0;
      end
   end

   assign rb.wr_en = phase_r && write_r && i_hready;
   assign rb.idx = idx_r;
   assign rb.wdata = i_hwdata;
   assign rb.mapped = mapped_r;

endmodule : tcm_ahb_slave

// [verilog/tcm_channel.sv]
/*
 * tcm_channel: compare value storage and reference output of one channel.
 * Assumes counter, update event, trigger event and filtered external
 * trigger arrive on the timer clock.
 */
`timescale 1ns/100ps
module tcm_channel (
   input wire logic i_clk,
   input wire logic i_nrst,
   input wire logic i_is_output,
   input wire tcm_pkg::tcm_mode_e i_mode,
   input wire logic i_fast,
   input wire logic i_preload,
   input wire logic i_clear_en,
   input wire logic i_etr,
   input wire logic i_trigger,
   input wire logic i_update,
   input wire logic [tcm_pkg::TCM_CNT_W-1:0] i_cnt,
   input wire logic i_cc_wr,
   input wire logic [tcm_pkg::TCM_CNT_W-1:0] i_cc_wdata,
   output logic o_ref,
   output logic [tcm_pkg::TCM_CNT_W-1:0] o_active_cc,
   output logic [tcm_pkg::TCM_CNT_W-1:0] o_buffer_cc
);
   import tcm_pkg::*;

   logic match;
   logic fast_hit;
   logic ref_nxt;

   // ----------------------------------------------------------------
   // compare value: direct or through the buffer
   // ----------------------------------------------------------------
   always_ff @(posedge i_clk or negedge i_nrst) begin
      if (!i_nrst) begin
         o_buffer_cc <= TCM_CC_RST;
      end else if (i_cc_wr) begin
         o_buffer_cc <= i_cc_wdata;
      end
   end

   always_ff @(posedge i_clk or negedge i_nrst) begin
      if (!i_nrst) begin
         o_active_cc <= TCM_CC_RST;
      end else if (i_cc_wr && !i_preload) begin
         o_active_cc <= i_cc_wdata;
      end else if (i_update && i_preload) begin
         o_active_cc <= o_buffer_cc;
      end
   end

   // ----------------------------------------------------------------
   // reference output
   // ----------------------------------------------------------------
   assign match = (i_cnt == o_active_cc);
   // fast response acts on the trigger edge itself, without waiting
   // for the counter to reach the compare value
   assign fast_hit = i_fast && i_trigger;

   always_comb begin
      ref_nxt = o_ref;
      case (i_mode)
         TCM_MODE_FREEZE: ref_nxt = o_ref;
         TCM_MODE_SET_MATCH: if (match || fast_hit) ref_nxt = 1'b1;
         TCM_MODE_CLR_MATCH: if (match || fast_hit) ref_nxt = 1'b0;
         TCM_MODE_TOGGLE: if (match || fast_hit) ref_nxt = !o_ref;
         TCM_MODE_FORCE_LOW: ref_nxt = 1'b0;
         TCM_MODE_FORCE_HIGH: ref_nxt = 1'b1;
         // pwm levels are re-evaluated every cycle, which also covers
         // a switch from freeze into a pwm mode
         TCM_MODE_PWM1: ref_nxt = fast_hit ? 1'b0 : (i_cnt < o_active_cc);
         TCM_MODE_PWM2: ref_nxt = fast_hit ? 1'b1 : (i_cnt > o_active_cc);
         default: ref_nxt = o_ref;
      endcase
      if (!i_is_output) begin
         ref_nxt = 1'b0;
      end
      if (i_clear_en && i_etr) begin
         ref_nxt = 1'b0;
      end
   end

   always_ff @(posedge i_clk or negedge i_nrst) begin
      if (!i_nrst) begin
         o_ref <= 1'b0;
      end else begin
         o_ref <= ref_nxt;
      end
   end

endmodule : tcm_channel

// [verilog/tcm_pkg.sv]
/*
 * tcm_pkg: shared constants and types of the timer compare-mode block:
 * register byte addresses, field positions of the channel pair mode control
 * register, reset values, channel direction and compare mode encodings.
 * Assumes a 32-bit AHB-Lite register port and a 16-bit timer counter.
 */
package tcm_pkg;

   // ----------------------------------------------------------------
   // widths
   // ----------------------------------------------------------------
   localparam int TCM_DATA_W = 32;
   localparam int TCM_CNT_W = 16;
   localparam int TCM_IDX_W = 6;
   localparam int TCM_NCH = 2;

   // ----------------------------------------------------------------
   // register byte addresses
   // ----------------------------------------------------------------
   localparam logic [31:0] TCM_ADDR_MODE = 32'h0000_0000;
   localparam logic [31:0] TCM_ADDR_CH1_CC = 32'h0000_0004;
   localparam logic [31:0] TCM_ADDR_CH2_CC = 32'h0000_0008;
   localparam logic [31:0] TCM_ADDR_CTRL = 32'h0000_000c;
   localparam logic [31:0] TCM_ADDR_STATUS = 32'h0000_0010;
   localparam logic [31:0] TCM_ADDR_CH1_ACT = 32'h0000_0014;
   localparam logic [31:0] TCM_ADDR_CH2_ACT = 32'h0000_0018;
   localparam logic [31:0] TCM_ADDR_SPAN = 32'h0000_00ff;

   // ----------------------------------------------------------------
   // mode control register fields, per channel byte
   // ----------------------------------------------------------------
   localparam int TCM_CH_STRIDE = 8;
   localparam int TCM_DIR_LSB = 0;
   localparam int TCM_DIR_MSB = 1;
   localparam int TCM_FAST_BIT = 2;
   localparam int TCM_PRE_BIT = 3;
   localparam int TCM_MODE_LSB = 4;
   localparam int TCM_MODE_MSB = 6;
   localparam int TCM_CLR_BIT = 7;
   localparam logic [7:0] TCM_PROT_MASK = 8'h78;

   // ----------------------------------------------------------------
   // control register fields and reset values
   // ----------------------------------------------------------------
   localparam int TCM_CTRL_EN1_BIT = 0;
   localparam int TCM_CTRL_EN2_BIT = 1;
   localparam int TCM_CTRL_SPM_BIT = 4;
   localparam int TCM_CTRL_PROT_LSB = 8;
   localparam int TCM_CTRL_PROT_MSB = 9;
   localparam logic [1:0] TCM_PROT_LOCKED = 2'h3;
   localparam logic [7:0] TCM_MODE_BYTE_RST = 8'h00;
   localparam logic [15:0] TCM_CC_RST = 16'h0000;

   // ----------------------------------------------------------------
   // bus constants
   // ----------------------------------------------------------------
   localparam logic [2:0] TCM_HSIZE_WORD = 3'h2;
   localparam int TCM_HTRANS_ACT_BIT = 1;

   // ----------------------------------------------------------------
   // encodings
   // ----------------------------------------------------------------
   typedef enum logic [1:0] {
      TCM_DIR_OUT = 2'b00,
      TCM_DIR_IN_A = 2'b01,
      TCM_DIR_IN_B = 2'b10,
      TCM_DIR_IN_TRG = 2'b11
   } tcm_dir_e;

   typedef enum logic [2:0] {
      TCM_MODE_FREEZE = 3'b000,
      TCM_MODE_SET_MATCH = 3'b001,
      TCM_MODE_CLR_MATCH = 3'b010,
      TCM_MODE_TOGGLE = 3'b011,
      TCM_MODE_FORCE_LOW = 3'b100,
      TCM_MODE_FORCE_HIGH = 3'b101,
      TCM_MODE_PWM1 = 3'b110,
      TCM_MODE_PWM2 = 3'b111
   } tcm_mode_e;

endpackage : tcm_pkg

// [verilog/tcm_regbus_if.sv]
/*
 * tcm_regbus_if: simple register port between the bus slave and the
 * register file of the top module. Assumes both ends share one clock.
 */
`timescale 1ns/100ps
interface tcm_regbus_if;
   logic wr_en;
   logic [tcm_pkg::TCM_IDX_W-1:0] idx;
   logic [tcm_pkg::TCM_DATA_W-1:0] wdata;
   logic [tcm_pkg::TCM_DATA_W-1:0] rdata;
   logic mapped;

   modport bus (output wr_en, output idx, output wdata, output mapped, input rdata);
   modport regs (input wr_en, input idx, input wdata, input mapped, output rdata);
endinterface : tcm_regbus_if

// [verilog/tcm_top.sv]
/*
 * tcm_top: output-compare configuration of timer channels 1 and 2 with
 * its register file behind an AHB-Lite slave. Holds the channel pair mode
 * control register, compare values, a control and a status register.
 * Assumes the counter, update event, trigger event and filtered external
 * trigger come from timer logic on i_clk; timer input pins and the internal
 * trigger source are asynchronous and are synchronised here.
 */
// Operation
// - ch1 direction: out, input one, two, trigger
// - ch2 direction: out, input two, one, trigger
// - fast enable shortens trigger to output delay
// - preload off: compare write acts at once
// - preload on: compare write waits for update
// - level 3 output: preload, mode writes ignored
// - freeze: matches leave reference unchanged
// - 001 sets high, 010 sets low on match
// - 011 toggles reference on each match
// - 100 forces low, 101 forces high
// - 110 high while counter below compare
// - 111 high while counter above compare
// - pwm level follows comparison and freeze exit
// - clear enable: external trigger high zeroes reference
// - ch2 controls at bits 10, 11, 14:12, 15
// - direction picks compare or capture meaning
`timescale 1ns/100ps
module tcm_top (
   input wire logic i_clk,
   input wire logic i_nrst,
   input wire logic i_hsel,
   input wire logic [31:0] i_haddr,
   input wire logic [1:0] i_htrans,
   input wire logic i_hwrite,
   input wire logic [2:0] i_hsize,
   input wire logic [31:0] i_hwdata,
   input wire logic i_hready,
   output logic [31:0] o_hrdata,
   output logic o_hreadyout,
   output logic o_hresp,
   input wire logic [tcm_pkg::TCM_CNT_W-1:0] i_counter_value,
   input wire logic i_update_event,
   input wire logic i_trigger_event,
   input wire logic i_filtered_external_trigger,
   input wire logic i_timer_input_one,
   input wire logic i_timer_input_two,
   input wire logic i_internal_trigger_source,
   output logic o_ch1_reference_output,
   output logic o_ch2_reference_output,
   output logic o_ch1_capture_input,
   output logic o_ch2_capture_input
);
   import tcm_pkg::*;

   // ----------------------------------------------------------------
   // helpers
   // ----------------------------------------------------------------
   // merge a software write into one channel byte of the mode register
   function automatic logic [7:0] tcm_merge_mode(
      input logic [7:0] old_b,
      input logic [7:0] new_b,
      input logic ch_enabled,
      input logic locked
   );
      logic [7:0] res;
      res = new_b;
      // direction only moves while the channel is switched off, so a
      // running output never changes meaning under software's feet
      if (ch_enabled) begin
         res[TCM_DIR_MSB:TCM_DIR_LSB] = old_b[TCM_DIR_MSB:TCM_DIR_LSB];
      end
      if (locked && (old_b[TCM_DIR_MSB:TCM_DIR_LSB] == TCM_DIR_OUT)) begin
         res = (res & ~TCM_PROT_MASK) | (old_b & TCM_PROT_MASK);
      end
      return res;
   endfunction : tcm_merge_mode

   // pick the capture input; channel 2 swaps the two timer inputs
   function automatic logic tcm_pick_input(
      input logic [1:0] dir,
      input logic swap,
      input logic in_one,
      input logic in_two,
      input logic in_trg
   );
      logic res;
      res = 1'b0;
      case (dir)
         TCM_DIR_IN_A: res = swap ? in_two : in_one;
         TCM_DIR_IN_B: res = swap ? in_one : in_two;
         TCM_DIR_IN_TRG: res = in_trg;
         default: res = 1'b0;
      endcase
      return res;
   endfunction : tcm_pick_input

   // ----------------------------------------------------------------
   // declarations
   // ----------------------------------------------------------------
   tcm_regbus_if rb ();

   logic [7:0] mode_byte_r [TCM_NCH];
   logic [TCM_NCH-1:0] out_en_r;
   logic single_pulse_r;
   logic [1:0] prot_level_r;
   logic [TCM_NCH-1:0] ch_is_out;
   logic [TCM_NCH-1:0] ch_fast;
   logic [TCM_NCH-1:0] ch_pre;
   logic [TCM_NCH-1:0] ch_clr;
   tcm_mode_e ch_mode [TCM_NCH];
   logic [TCM_NCH-1:0] cc_wr;
   logic [TCM_NCH-1:0] ch_ref;
   logic [TCM_CNT_W-1:0] act_cc [TCM_NCH];
   logic [TCM_CNT_W-1:0] buf_cc [TCM_NCH];
   logic [2:0] pin_meta_r;
   logic [2:0] pin_sync_r;
   logic wr_mode;
   logic wr_ctrl;
   logic [15:0] mode_word;
   logic [31:0] status_word;
   logic [31:0] ctrl_word;

   // ----------------------------------------------------------------
   // bus slave
   // ----------------------------------------------------------------
   tcm_ahb_slave u_ahb (
      .i_clk (i_clk),
      .i_nrst (i_nrst),
      .i_hsel (i_hsel),
      .i_haddr (i_haddr),
      .i_htrans (i_htrans),
      .i_hwrite (i_hwrite),
      .i_hsize (i_hsize),
      .i_hwdata (i_hwdata),
      .i_hready (i_hready),
      .o_hrdata (o_hrdata),
      .o_hreadyout (o_hreadyout),
      .o_hresp (o_hresp),
      .rb (rb.bus)
   );

   assign wr_mode = rb.wr_en && rb.mapped && (rb.idx == TCM_ADDR_MODE[TCM_IDX_W+1:2]);
   assign wr_ctrl = rb.wr_en && rb.mapped && (rb.idx == TCM_ADDR_CTRL[TCM_IDX_W+1:2]);
   assign cc_wr[0] = rb.wr_en && rb.mapped && (rb.idx == TCM_ADDR_CH1_CC[TCM_IDX_W+1:2]);
   assign cc_wr[1] = rb.wr_en && rb.mapped && (rb.idx == TCM_ADDR_CH2_CC[TCM_IDX_W+1:2]);

   // ----------------------------------------------------------------
   // pin synchronisers: timer input one, two, internal trigger
   // ----------------------------------------------------------------
   always_ff @(posedge i_clk or negedge i_nrst) begin
      if (!i_nrst) begin
         pin_meta_r <= '0;
         pin_sync_r <= '0;
      end else begin
         pin_meta_r <= {i_internal_trigger_source, i_timer_input_two, i_timer_input_one};
         pin_sync_r <= pin_meta_r;
      end
   end

   // ----------------------------------------------------------------
   // control register: output enables, single pulse, protection level
   // ----------------------------------------------------------------
   always_ff @(posedge i_clk or negedge i_nrst) begin
      if (!i_nrst) begin
         out_en_r <= '0;
         single_pulse_r <= 1'b0;
         prot_level_r <= '0;
      end else if (wr_ctrl) begin
         out_en_r[0] <= rb.wdata[TCM_CTRL_EN1_BIT];
         out_en_r[1] <= rb.wdata[TCM_CTRL_EN2_BIT];
         // kept for software only; pwm without preload outside single
         // pulse gives an undefined output and is software's to avoid
         single_pulse_r <= rb.wdata[TCM_CTRL_SPM_BIT];
         prot_level_r <= rb.wdata[TCM_CTRL_PROT_MSB:TCM_CTRL_PROT_LSB];
      end
   end

   // ----------------------------------------------------------------
   // per channel mode byte, field decode and compare channel
   // ----------------------------------------------------------------
   for (genvar g = 0; g < TCM_NCH; g++) begin : g_ch
      always_ff @(posedge i_clk or negedge i_nrst) begin
         if (!i_nrst) begin
            mode_byte_r[g] <= TCM_MODE_BYTE_RST;
         end else if (wr_mode) begin
            mode_byte_r[g] <= tcm_merge_mode(mode_byte_r[g],
               rb.wdata[g*TCM_CH_STRIDE +: TCM_CH_STRIDE], out_en_r[g],
               prot_level_r == TCM_PROT_LOCKED);
         end
      end

      // bits above the direction field mean compare controls only while
      // the direction selects output
      assign ch_is_out[g] = (mode_byte_r[g][TCM_DIR_MSB:TCM_DIR_LSB] == TCM_DIR_OUT);
      assign ch_fast[g] = ch_is_out[g] && mode_byte_r[g][TCM_FAST_BIT];
      assign ch_pre[g] = ch_is_out[g] && mode_byte_r[g][TCM_PRE_BIT];
      assign ch_clr[g] = ch_is_out[g] && mode_byte_r[g][TCM_CLR_BIT];
      assign ch_mode[g] = tcm_mode_e'(mode_byte_r[g][TCM_MODE_MSB:TCM_MODE_LSB]);

      tcm_channel u_ch (
         .i_clk (i_clk),
         .i_nrst (i_nrst),
         .i_is_output (ch_is_out[g]),
         .i_mode (ch_mode[g]),
         .i_fast (ch_fast[g]),
         .i_preload (ch_pre[g]),
         .i_clear_en (ch_clr[g]),
         .i_etr (i_filtered_external_trigger),
         .i_trigger (i_trigger_event),
         .i_update (i_update_event),
         .i_cnt (i_counter_value),
         .i_cc_wr (cc_wr[g]),
         .i_cc_wdata (rb.wdata[TCM_CNT_W-1:0]),
         .o_ref (ch_ref[g]),
         .o_active_cc (act_cc[g]),
         .o_buffer_cc (buf_cc[g])
      );
   end

   // ----------------------------------------------------------------
   // outputs
   // ----------------------------------------------------------------
   always_ff @(posedge i_clk or negedge i_nrst) begin
      if (!i_nrst) begin
         o_ch1_reference_output <= 1'b0;
         o_ch2_reference_output <= 1'b0;
      end else begin
         o_ch1_reference_output <= ch_ref[0];
         o_ch2_reference_output <= ch_ref[1];
      end
   end

   always_ff @(posedge i_clk or negedge i_nrst) begin
      if (!i_nrst) begin
         o_ch1_capture_input <= 1'b0;
         o_ch2_capture_input <= 1'b0;
      end else begin
         o_ch1_capture_input <= tcm_pick_input(mode_byte_r[0][TCM_DIR_MSB:TCM_DIR_LSB],
            1'b0, pin_sync_r[0], pin_sync_r[1], pin_sync_r[2]);
         o_ch2_capture_input <= tcm_pick_input(mode_byte_r[1][TCM_DIR_MSB:TCM_DIR_LSB],
            1'b1, pin_sync_r[0], pin_sync_r[1], pin_sync_r[2]);
      end
   end

   // ----------------------------------------------------------------
   // read mux
   // ----------------------------------------------------------------
   assign mode_word = {mode_byte_r[1], mode_byte_r[0]};

   always_comb begin
      ctrl_word = '0;
      ctrl_word[TCM_CTRL_EN1_BIT] = out_en_r[0];
      ctrl_word[TCM_CTRL_EN2_BIT] = out_en_r[1];
      ctrl_word[TCM_CTRL_SPM_BIT] = single_pulse_r;
      ctrl_word[TCM_CTRL_PROT_MSB:TCM_CTRL_PROT_LSB] = prot_level_r;
   end

   always_comb begin
      status_word = '0;
      status_word[0] = ch_ref[0];
      status_word[1] = ch_ref[1];
      status_word[2] = ch_is_out[0];
      status_word[3] = ch_is_out[1];
      status_word[4] = o_ch1_capture_input;
      status_word[5] = o_ch2_capture_input;
   end

   always_comb begin
      rb.rdata = '0;
      if (rb.mapped) begin
         case ({rb.idx, 2'b00})
            TCM_ADDR_MODE[TCM_IDX_W+1:0]: rb.rdata = {16'h0000, mode_word};
            TCM_ADDR_CH1_CC[TCM_IDX_W+1:0]: rb.rdata = {16'h0000, buf_cc[0]};
            TCM_ADDR_CH2_CC[TCM_IDX_W+1:0]: rb.rdata = {16'h0000, buf_cc[1]};
            TCM_ADDR_CTRL[TCM_IDX_W+1:0]: rb.rdata = ctrl_word;
            TCM_ADDR_STATUS[TCM_IDX_W+1:0]: rb.rdata = status_word;
            TCM_ADDR_CH1_ACT[TCM_IDX_W+1:0]: rb.rdata = {16'h0000, act_cc[0]};
            TCM_ADDR_CH2_ACT[TCM_IDX_W+1:0]: rb.rdata = {16'h0000, act_cc[1]};
            default: rb.rdata = '0;
         endcase
      end
   end

endmodule : tcm_top
